// file: core/frame_sync_shadow_regs.sv
// Sync control slice: holds exposure, gain and commit control registers,
// and moves shadow settings to active copies on frame or exposure events.
// Assumes all event and value inputs come from logic on clk_i.
// Operation
// - Hold a 16-bit third-slope integration time, counted in tick units.
// - Latency bit set with gain sync bit set delays new gain settings by one extra frame.
// - Readout span sync bit set: apply span only at frame start.
// - Dark row sync bit set: new dark count only at frame start.
// - Padding row sync bit set: new padding count only at frame start.
// - Exposure sync bit set: commit exposure at overhead start, else unsynchronised.
// - Gain sync bit set: commit gain settings at frame start, else immediately.
// - Region sync bit set: commit region selection at frame start.
// - Region blanking bit set: blank first frame after region change; with region sync set, the second frame with the new region.
// - Subsampling change blanks first frame; snapshot only when bit set.
// - Continuous bit clear: exposure syncs at overhead start when sync bit set, else immediately; set with sync bit set: continuous.
// - Continuous mode with sync bit clear holds exposure updates until frame start.
// - Tick divider in system clocks is the exposure time unit.
`timescale 1ns/1ps
module frame_sync_shadow_regs #(
    parameter int unsigned SPAN_W = 8,
    parameter int unsigned DARK_W = 8,
    parameter int unsigned PAD_W  = 12,
    parameter int unsigned ROI_W  = 8
) (
    // Clock and reset
    input  wire logic                                   clk_i,
    input  wire logic                                   srst_i,
    // Register port
    input  wire logic [frame_sync_pkg::ADDR_W-1:0]      reg_addr_i,
    input  wire logic                                   reg_wr_i,
    input  wire logic [frame_sync_pkg::DATA_W-1:0]      reg_wdata_i,
    output logic      [frame_sync_pkg::DATA_W-1:0]      reg_rdata_o,
    // Frame timing events and modes
    input  wire logic                                   frame_start_i,
    input  wire logic                                   overhead_start_i,
    input  wire logic                                   rolling_i,
    input  wire logic                                   subsample_change_i,
    input  wire logic [frame_sync_pkg::DATA_W-1:0]      tick_divider_i,
    // Written values held by neighbouring slices
    input  wire logic [SPAN_W-1:0]                      span_value_i,
    input  wire logic [DARK_W-1:0]                      dark_value_i,
    input  wire logic [PAD_W-1:0]                       pad_value_i,
    input  wire logic [ROI_W-1:0]                       roi_value_i,
    // Active settings
    output logic      [frame_sync_pkg::DATA_W-1:0]      third_slope_o,
    output frame_sync_pkg::amp_set_t                    amp_o,
    output logic      [SPAN_W-1:0]                      span_o,
    output logic      [DARK_W-1:0]                      dark_o,
    output logic      [PAD_W-1:0]                       pad_o,
    output logic      [ROI_W-1:0]                       roi_o,
    output logic                                        blank_frame_o,
    output logic                                        exp_tick_o
);
    logic [15:0] third_sh_ff, nxt_third_sh;
    logic [15:0] analog_ff, nxt_analog;
    logic [15:0] digital_ff, nxt_digital;
    logic [15:0] ctrl_ff, nxt_ctrl;
    logic [15:0] rdata_ff, nxt_rdata;
    logic [15:0] third_act_ff, nxt_third_act;
    frame_sync_pkg::amp_set_t amp_sh, amp_stage_ff, nxt_amp_stage, amp_act_ff, nxt_amp_act;
    logic [SPAN_W-1:0] span_ff, nxt_span;
    logic [DARK_W-1:0] dark_ff, nxt_dark;
    logic [PAD_W-1:0]  pad_ff, nxt_pad;
    logic [ROI_W-1:0]  roi_ff, nxt_roi;
    logic blank_pend_ff, nxt_blank_pend, blank_ff, nxt_blank;
    logic [15:0] tick_cnt_ff, nxt_tick_cnt;
    logic tick_ff, nxt_tick;
    logic exp_commit, gain_commit, roi_change;

    // Sync choice: set bit waits for the event, clear bit follows every cycle
    function automatic logic commit_on(input logic sync_bit, input logic event_pulse);
        return sync_bit ? event_pulse : 1'b1;
    endfunction

    // Register file
    always_comb begin
        nxt_third_sh = third_sh_ff;
        nxt_analog   = analog_ff;
        nxt_digital  = digital_ff;
        nxt_ctrl     = ctrl_ff;
        if (reg_wr_i) begin
            case (reg_addr_i)
                frame_sync_pkg::OFS_THIRD_SLOPE: nxt_third_sh = reg_wdata_i;
                frame_sync_pkg::OFS_ANALOG_AMP:
                    nxt_analog = reg_wdata_i & frame_sync_pkg::MSK_ANALOG_AMP;
                frame_sync_pkg::OFS_DIGITAL_AMP:
                    nxt_digital = reg_wdata_i & frame_sync_pkg::MSK_DIGITAL_AMP;
                frame_sync_pkg::OFS_COMMIT_CTRL:
                    nxt_ctrl = reg_wdata_i & frame_sync_pkg::MSK_COMMIT_CTRL;
                default: ;
            endcase
        end
        case (reg_addr_i)
            frame_sync_pkg::OFS_THIRD_SLOPE: nxt_rdata = third_sh_ff;
            frame_sync_pkg::OFS_ANALOG_AMP:  nxt_rdata = analog_ff;
            frame_sync_pkg::OFS_DIGITAL_AMP: nxt_rdata = digital_ff;
            frame_sync_pkg::OFS_COMMIT_CTRL: nxt_rdata = ctrl_ff;
            default:                         nxt_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            third_sh_ff <= frame_sync_pkg::RST_THIRD_SLOPE;
            analog_ff   <= frame_sync_pkg::RST_ANALOG_AMP;
            digital_ff  <= frame_sync_pkg::RST_DIGITAL_AMP;
            ctrl_ff     <= frame_sync_pkg::RST_COMMIT_CTRL;
            rdata_ff    <= 16'h0000;
        end else begin
            third_sh_ff <= nxt_third_sh;
            analog_ff   <= nxt_analog;
            digital_ff  <= nxt_digital;
            ctrl_ff     <= nxt_ctrl;
            rdata_ff    <= nxt_rdata;
        end
    end

    assign amp_sh = '{analog: analog_ff[12:0], digital_amplification: digital_ff[11:0]};

    // Commit logic; continuous mode with sync clear falls back to frame start
    always_comb begin
        if (ctrl_ff[frame_sync_pkg::BIT_EXP_CONT])
            exp_commit = ctrl_ff[frame_sync_pkg::BIT_EXP_SYNC] | frame_start_i;
        else
            exp_commit = commit_on(ctrl_ff[frame_sync_pkg::BIT_EXP_SYNC],
                                   overhead_start_i);
        gain_commit   = commit_on(ctrl_ff[frame_sync_pkg::BIT_GAIN_SYNC], frame_start_i);
        nxt_third_act = exp_commit ? third_sh_ff : third_act_ff;
        nxt_amp_stage = amp_stage_ff;
        nxt_amp_act   = amp_act_ff;
        if (gain_commit) begin
            nxt_amp_stage = amp_sh;
            // Lagging by a frame keeps gain aligned with exposure that lands late
            if (analog_ff[frame_sync_pkg::BIT_LAT_COMP] && ctrl_ff[frame_sync_pkg::BIT_GAIN_SYNC])
                nxt_amp_act = amp_stage_ff;
            else
                nxt_amp_act = amp_sh;
        end
        nxt_span = commit_on(ctrl_ff[frame_sync_pkg::BIT_SPAN_SYNC], frame_start_i)
                   ? span_value_i : span_ff;
        nxt_dark = commit_on(ctrl_ff[frame_sync_pkg::BIT_DARK_SYNC], frame_start_i)
                   ? dark_value_i : dark_ff;
        nxt_pad  = commit_on(ctrl_ff[frame_sync_pkg::BIT_PAD_SYNC], frame_start_i)
                   ? pad_value_i : pad_ff;
        nxt_roi  = commit_on(ctrl_ff[frame_sync_pkg::BIT_ROI_SYNC], frame_start_i)
                   ? roi_value_i : roi_ff;
        roi_change = (nxt_roi != roi_ff);
        // A new request in the clearing cycle stays pending for the next frame
        nxt_blank_pend = (blank_pend_ff & ~frame_start_i)
                       | (roi_change & ctrl_ff[frame_sync_pkg::BIT_BLANK_ROI])
                       | (subsample_change_i
                          & (rolling_i | ctrl_ff[frame_sync_pkg::BIT_BLANK_SUBS]));
        nxt_blank = frame_start_i ? blank_pend_ff : blank_ff;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            third_act_ff  <= frame_sync_pkg::RST_THIRD_SLOPE;
            amp_stage_ff  <= '0;
            amp_act_ff    <= '0;
            span_ff       <= '0;
            dark_ff       <= '0;
            pad_ff        <= '0;
            roi_ff        <= '0;
            blank_pend_ff <= 1'b0;
            blank_ff      <= 1'b0;
        end else begin
            third_act_ff  <= nxt_third_act;
            amp_stage_ff  <= nxt_amp_stage;
            amp_act_ff    <= nxt_amp_act;
            span_ff       <= nxt_span;
            dark_ff       <= nxt_dark;
            pad_ff        <= nxt_pad;
            roi_ff        <= nxt_roi;
            blank_pend_ff <= nxt_blank_pend;
            blank_ff      <= nxt_blank;
        end
    end

    // Exposure tick divider; a zero divider behaves as one
    always_comb begin
        nxt_tick     = 1'b0;
        nxt_tick_cnt = tick_cnt_ff + 16'h0001;
        if (tick_cnt_ff + 16'h0001 >= tick_divider_i) begin
            nxt_tick_cnt = 16'h0000;
            nxt_tick     = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tick_cnt_ff <= 16'h0000;
            tick_ff     <= 1'b0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            tick_ff     <= nxt_tick;
        end
    end

    assign reg_rdata_o   = rdata_ff;
    assign third_slope_o = third_act_ff;
    assign amp_o         = amp_act_ff;
    assign span_o        = span_ff;
    assign dark_o        = dark_ff;
    assign pad_o         = pad_ff;
    assign roi_o         = roi_ff;
    assign blank_frame_o = blank_ff;
    assign exp_tick_o    = tick_ff;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    exp_immediate_a: assert property (
        !ctrl_ff[3] && !ctrl_ff[10] |=> third_act_ff == $past(third_sh_ff))
        else $error("exposure not committed at once");
    exp_overhead_hold_a: assert property (
        ctrl_ff[3] && !ctrl_ff[10] && !overhead_start_i |=> $stable(third_act_ff))
        else $error("exposure moved outside overhead start");
    exp_overhead_take_a: assert property (
        ctrl_ff[3] && !ctrl_ff[10] && overhead_start_i |=> third_act_ff == $past(third_sh_ff))
        else $error("exposure not taken at overhead start");
    exp_cont_hold_a: assert property (
        ctrl_ff[10] && !ctrl_ff[3] && !frame_start_i |=> $stable(third_act_ff))
        else $error("continuous exposure ignored sync bit");
    gain_direct_a: assert property (
        ctrl_ff[4] && !analog_ff[13] && frame_start_i |=> amp_act_ff == $past(amp_sh))
        else $error("gain not applied at frame start");
    gain_latency_a: assert property (
        ctrl_ff[4] && analog_ff[13] && frame_start_i |=> amp_act_ff == $past(amp_stage_ff))
        else $error("gain latency stage skipped");
    span_sync_a: assert property (
        ctrl_ff[0] && !frame_start_i |=> $stable(span_ff))
        else $error("span moved off frame start");
    dark_direct_a: assert property (
        !ctrl_ff[1] |=> dark_ff == $past(dark_value_i))
        else $error("dark count not immediate");
    pad_sync_a: assert property (
        ctrl_ff[2] && !frame_start_i |=> $stable(pad_ff))
        else $error("padding moved off frame start");
    roi_blank_a: assert property (
        ctrl_ff[8] && !ctrl_ff[5] && roi_value_i != roi_ff ##1 frame_start_i
        |=> blank_frame_o)
        else $error("region change not blanked");
    subs_blank_a: assert property (
        subsample_change_i && rolling_i ##1 frame_start_i |=> blank_frame_o)
        else $error("rolling subsample change not blanked");
    // Last step excuses a divider that moved after the window opened
    tick_period_a: assert property (
        tick_divider_i == 16'h0003 && $stable(tick_divider_i) && exp_tick_o
        ##1 $stable(tick_divider_i) |-> !exp_tick_o ##1 !exp_tick_o
        ##1 (exp_tick_o || $past(tick_divider_i) != 16'h0003))
        else $error("tick period wrong");

    blank_cover_c: cover property (blank_frame_o && frame_start_i);
    lat_cover_c:   cover property (ctrl_ff[4] && analog_ff[13] && frame_start_i);
    cont_cover_c:  cover property (ctrl_ff[10] && ctrl_ff[3] && reg_wr_i);
endmodule // frame_sync_shadow_regs

// file: core/frame_sync_pkg.sv
// Constants and carrier types for the frame-synchronised register slice.
// Assumes a register offset port decoded upstream from the serial configuration port.
package frame_sync_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_THIRD_SLOPE = 8'h0B;
    localparam logic [ADDR_W-1:0] OFS_ANALOG_AMP  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_DIGITAL_AMP = 8'h0D;
    localparam logic [ADDR_W-1:0] OFS_COMMIT_CTRL = 8'h0E;

    // Reset values
    localparam logic [DATA_W-1:0] RST_THIRD_SLOPE = 16'h0000;
    localparam logic [DATA_W-1:0] RST_ANALOG_AMP  = 16'h01E2;
    localparam logic [DATA_W-1:0] RST_DIGITAL_AMP = 16'h0080;
    localparam logic [DATA_W-1:0] RST_COMMIT_CTRL = 16'h033F;

    // Implemented bits; the rest read as zero
    localparam logic [DATA_W-1:0] MSK_ANALOG_AMP  = 16'h3FFF;
    localparam logic [DATA_W-1:0] MSK_DIGITAL_AMP = 16'h0FFF;
    localparam logic [DATA_W-1:0] MSK_COMMIT_CTRL = 16'h073F;

    // Commit control bit positions
    localparam int unsigned BIT_SPAN_SYNC    = 0;
    localparam int unsigned BIT_DARK_SYNC    = 1;
    localparam int unsigned BIT_PAD_SYNC     = 2;
    localparam int unsigned BIT_EXP_SYNC     = 3;
    localparam int unsigned BIT_GAIN_SYNC    = 4;
    localparam int unsigned BIT_ROI_SYNC     = 5;
    localparam int unsigned BIT_BLANK_ROI    = 8;
    localparam int unsigned BIT_BLANK_SUBS   = 9;
    localparam int unsigned BIT_EXP_CONT     = 10;

    // Analog amplifier field layout
    localparam int unsigned BIT_LAT_COMP     = 13;

    typedef struct packed {
        logic [7:0] second_amp_step;
        logic [4:0] first_amp_step;
    } analog_amp_t;

    typedef struct packed {
        analog_amp_t analog;
        logic [11:0] digital_amplification;
    } amp_set_t;

    localparam logic [DATA_W-1:0] TICK_RST = 16'h0001;
endpackage

// file: verification/frame_sync_shadow_regs_tb.sv
// Self-checking bench for the frame-synchronised register slice.
// Assumes the design package is compiled first; inputs change at the falling edge.
`timescale 1ns/1ps
module frame_sync_shadow_regs_tb;
    logic                     clk_i = 1'b0;
    logic                     srst_i = 1'b1;
    logic [7:0]               reg_addr_i = 8'h00;
    logic                     reg_wr_i = 1'b0;
    logic [15:0]              reg_wdata_i = 16'h0000;
    logic [15:0]              reg_rdata_o;
    logic                     frame_start_i = 1'b0;
    logic                     overhead_start_i = 1'b0;
    logic                     rolling_i = 1'b0;
    logic                     subsample_change_i = 1'b0;
    logic [15:0]              tick_divider_i = frame_sync_pkg::TICK_RST;
    logic [11:0]              val [4] = '{default: 12'h000};
    logic [15:0]              third_slope_o;
    frame_sync_pkg::amp_set_t amp_o;
    logic [7:0]               span_o;
    logic [7:0]               dark_o;
    logic [11:0]              pad_o;
    logic [7:0]               roi_o;
    logic                     blank_frame_o;
    logic                     exp_tick_o;
    // Bench model of the register table and the active copies
    logic [15:0]              regm [4] = '{16'h0000, 16'h01E2, 16'h0080, 16'h033F};
    logic [15:0]              msk [4] = '{16'hFFFF, 16'h3FFF, 16'h0FFF, 16'h073F};
    logic [11:0]              wm [4] = '{12'h0FF, 12'h0FF, 12'hFFF, 12'h0FF};
    logic [11:0]              actm [4] = '{default: 12'h000};
    int                       pos [4] = '{0, 1, 2, 5};
    int                       err_count = 0;
    int                       checks = 0;
    logic [15:0]              d, e, a, b, g;
    int                       n, dv;

    frame_sync_shadow_regs u_dut (
        .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .frame_start_i(frame_start_i),
        .overhead_start_i(overhead_start_i), .rolling_i(rolling_i),
        .subsample_change_i(subsample_change_i), .tick_divider_i(tick_divider_i),
        .span_value_i(val[0][7:0]), .dark_value_i(val[1][7:0]), .pad_value_i(val[2]),
        .roi_value_i(val[3][7:0]), .third_slope_o(third_slope_o), .amp_o(amp_o),
        .span_o(span_o), .dark_o(dark_o), .pad_o(pad_o), .roi_o(roi_o),
        .blank_frame_o(blank_frame_o), .exp_tick_o(exp_tick_o)
    );

    always #5 clk_i = ~clk_i;

    task automatic give_verdict();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        checks++;
        if (seen !== expd) begin
            err_count++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk_i);
    endtask

    // Strobe drops for a cycle between writes so no signal is driven twice in one step
    task automatic wr(input logic [7:0] ad, input logic [15:0] dt);
        reg_addr_i = ad;
        reg_wdata_i = dt;
        reg_wr_i = 1'b1;
        cyc(1);
        reg_wr_i = 1'b0;
        cyc(1);
        if (ad >= 8'h0B && ad <= 8'h0E) regm[ad - 8'h0B] = dt & msk[ad - 8'h0B];
    endtask

    task automatic rd(input logic [7:0] ad);
        reg_addr_i = ad;
        cyc(2);
        check(32'(reg_rdata_o), (ad >= 8'h0B && ad <= 8'h0E) ? 32'(regm[ad - 8'h0B]) : 0);
    endtask

    task automatic fs();
        frame_start_i = 1'b1;
        cyc(1);
        frame_start_i = 1'b0;
        cyc(2);
    endtask

    task automatic oh();
        overhead_start_i = 1'b1;
        cyc(1);
        overhead_start_i = 1'b0;
        cyc(2);
    endtask

    function automatic logic [31:0] act(input int i);
        case (i)
            0: return 32'(span_o);
            1: return 32'(dark_o);
            2: return 32'(pad_o);
            default: return 32'(roi_o);
        endcase
    endfunction

    function automatic logic [31:0] ampx(input logic [15:0] an, input logic [15:0] dg);
        return {7'h00, an[12:0], dg[11:0]};
    endfunction

    task automatic cmp_vals();
        for (int j = 0; j < 4; j++) check(act(j), 32'(actm[j]));
    endtask

    initial begin
        #300000;
        err_count++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'hD1A784EA));
        cyc(12);
        srst_i = 1'b0;
        for (int k = 10; k <= 16; k++) rd(8'(k));
        for (int k = 11; k <= 16; k++) wr(8'(k), 16'($urandom));
        for (int k = 10; k <= 16; k++) rd(8'(k));
        // Exposure commit paths
        wr(8'h0E, 16'h0000);
        d = 16'($urandom);
        wr(8'h0B, d);
        cyc(1);
        check(32'(third_slope_o), 32'(d));
        wr(8'h0E, 16'h0008);
        e = 16'($urandom);
        wr(8'h0B, e);
        fs();
        check(32'(third_slope_o), 32'(d));
        oh();
        check(32'(third_slope_o), 32'(e));
        wr(8'h0E, 16'h0400);
        d = 16'($urandom);
        wr(8'h0B, d);
        oh();
        check(32'(third_slope_o), 32'(e));
        fs();
        check(32'(third_slope_o), 32'(d));
        wr(8'h0E, 16'h0408);
        e = 16'($urandom);
        wr(8'h0B, e);
        cyc(1);
        check(32'(third_slope_o), 32'(e));
        // Gain commit paths; latency is tested with only the analog word changing
        wr(8'h0E, 16'h0000);
        a = 16'($urandom) & 16'h1FFF;
        g = 16'($urandom);
        wr(8'h0C, a);
        wr(8'h0D, g);
        cyc(1);
        check(32'(amp_o), ampx(a, g));
        wr(8'h0E, 16'h0010);
        b = 16'($urandom) & 16'h1FFF;
        wr(8'h0C, b);
        cyc(2);
        check(32'(amp_o), ampx(a, g));
        fs();
        check(32'(amp_o), ampx(b, g));
        a = 16'($urandom) | 16'h2000;
        wr(8'h0C, a);
        fs();
        fs();
        b = 16'($urandom) | 16'h2000;
        wr(8'h0C, b);
        fs();
        check(32'(amp_o), ampx(a, g));
        fs();
        check(32'(amp_o), ampx(b, g));
        // Each row-count or region sync bit cleared in turn
        for (int i = 0; i < 4; i++) begin
            wr(8'h0E, 16'h003F & ~(16'h0001 << pos[i]));
            for (int j = 0; j < 4; j++) val[j] = 12'($urandom) & wm[j];
            cyc(3);
            actm[i] = val[i];
            cmp_vals();
            fs();
            for (int j = 0; j < 4; j++) actm[j] = val[j];
            cmp_vals();
        end
        // Blanking after a region switch and a subsampling switch
        wr(8'h0E, 16'h0100);
        val[3] = val[3] ^ 12'h001;
        cyc(1);
        fs();
        check(32'(blank_frame_o), 1);
        fs();
        check(32'(blank_frame_o), 0);
        wr(8'h0E, 16'h0000);
        val[3] = val[3] ^ 12'h001;
        cyc(3);
        fs();
        check(32'(blank_frame_o), 0);
        for (int k = 0; k < 4; k++) begin
            wr(8'h0E, k[0] ? 16'h0200 : 16'h0000);
            rolling_i = k[1];
            subsample_change_i = 1'b1;
            cyc(1);
            subsample_change_i = 1'b0;
            fs();
            check(32'(blank_frame_o), 32'(k != 0));
            fs();
        end
        // Tick spacing: first divider fixed at three so the period property fires
        for (int k = 0; k < 3; k++) begin
            dv = (k == 0) ? 3 : 1 + int'($urandom % 7);
            tick_divider_i = 16'(dv);
            cyc(20);
            n = 0;
            repeat (6 * dv) begin
                cyc(1);
                n += int'(exp_tick_o === 1'b1);
            end
            check(32'(n), 32'd6);
        end
        give_verdict();
    end
endmodule // frame_sync_shadow_regs_tb
